// [rtl/dac_wave_top.sv]
`timescale 1ns/1ps
`include "dac_wave_defines.svh"

// Overview of operation
// - Phase field decodes 0, 120, 240, 90 degrees
// - Waveform field picks triangle, saw, inverse, off; the sine code runs the triangle sequence
// - Mode bit low selects linear slew
// - Linear step sizes 1,2,3,4,6,8,16,32 LSB
// - Linear interval codes map 4 to 5127.92 us
// - Interval code zero jumps to margin directly
// - Mode bit high slews logarithmically between margins
// - Upward log step grows by 1/32
// - Downward log step shrinks by 1/32
// - Zero low margin starts log slew at one
// - Rising interval field times upward log slews
// - Falling interval field times downward log slews
// - Output code left aligned, low nibble ignored
// - Ten-bit variant ignores two further bits
// - Output codes at 1Ch, 19h, reset zero
// - PMBus reaches codes via page then 21h
// - Sync bit defers update to load trigger

module dac_wave_top
    import wave_pkg::*;
#(
    parameter int RES_BITS = 12,
    parameter int TICK_CYCLES = `TB_CYCLES
)
(
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic PMBUS_SEL,
    input wire logic [7:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [15:0] REG_RDATA,
    output logic REG_RVALID,
    input wire logic LOAD_OUTPUT_TRIGGER_N,
    input wire logic SW_LOAD,
    input wire logic [11:0] MARGIN_HIGH0,
    input wire logic [11:0] MARGIN_LOW0,
    input wire logic [11:0] MARGIN_HIGH1,
    input wire logic [11:0] MARGIN_LOW1,
    input wire logic [1:0] MARGIN_EN,
    input wire logic [1:0] MARGIN_HIGH_SEL,
    output logic [11:0] OUT_CODE0,
    output logic [11:0] OUT_CODE1,
    output logic [8:0] PHASE_DEG0,
    output logic [8:0] PHASE_DEG1
);

    localparam int CODE_W = 12;
    localparam int TC_W = 8;
    // Bits of the left-aligned field that a narrower variant stores
    localparam logic [15:0] DATA_MASK = 16'(((1 << RES_BITS) - 1) << (16 - RES_BITS));

    // ==========
    // Registers
    logic [15:0] wavegen_config_field0_reg, wavegen_config_field0_next;
    logic [15:0] wavegen_config_field1_reg, wavegen_config_field1_next;
    logic [15:0] chan0_output_code_reg, chan0_output_code_next;
    logic [15:0] chan1_output_code_reg, chan1_output_code_next;
    logic [7:0] page_reg, page_next;
    logic [15:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    logic [CODE_W-1:0] active0_reg, active0_next;
    logic [CODE_W-1:0] active1_reg, active1_next;
    logic [8:0] phase0_reg, phase0_next;
    logic [8:0] phase1_reg, phase1_next;

    logic sel_cfg0, sel_cfg1, sel_data0, sel_data1, sel_page;
    logic [15:0] wr_data_masked;
    logic load_evt;

    function automatic logic [8:0] phase_deg(input logic [1:0] sel);
        case (sel)
            2'h1: phase_deg = `PH_DEG_120;
            2'h2: phase_deg = `PH_DEG_240;
            2'h3: phase_deg = `PH_DEG_90;
            default: phase_deg = `PH_DEG_0;
        endcase
    endfunction

    // ==========
    // Load trigger pin: three stages, falling edge once the last two stages agree
    logic [2:0] ld_sync_reg, ld_sync_next;
    logic ld_level_reg, ld_level_next;
    logic pin_fall;

    always_comb
    begin
        ld_sync_next = {ld_sync_reg[1:0], LOAD_OUTPUT_TRIGGER_N};
        ld_level_next = ld_level_reg;
        if (ld_sync_reg[1] == ld_sync_reg[2])
            ld_level_next = ld_sync_reg[2];
        pin_fall = ld_level_reg && !ld_level_next;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            ld_sync_reg <= 3'h7;
            ld_level_reg <= 1'b1;
        end
        else
        begin
            ld_sync_reg <= ld_sync_next;
            ld_level_reg <= ld_level_next;
        end
    end

    // ==========
    // Time base divider
    logic [TC_W-1:0] tb_cnt_reg, tb_cnt_next;
    logic tick_reg, tick_next;

    always_comb
    begin
        tick_next = (tb_cnt_reg == TC_W'(TICK_CYCLES - 1));
        tb_cnt_next = tick_next ? '0 : tb_cnt_reg + TC_W'(1);
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            tb_cnt_reg <= '0;
            tick_reg <= 1'b0;
        end
        else
        begin
            tb_cnt_reg <= tb_cnt_next;
            tick_reg <= tick_next;
        end
    end

    // ==========
    // Register access
    always_comb
    begin
        // Direct map and PMBus map share one port; the page steers PMBus
        if (PMBUS_SEL)
        begin
            sel_page = (REG_ADDR == `PM_PAGE_CMD);
            sel_cfg0 = (page_reg == `PM_PAGE_COMMON) && (REG_ADDR == `PM_CFG0_CMD);
            sel_cfg1 = (page_reg == `PM_PAGE_COMMON) && (REG_ADDR == `PM_CFG1_CMD);
            sel_data0 = (page_reg == `PM_PAGE_CH0) && (REG_ADDR == `PM_DATA_CMD);
            sel_data1 = (page_reg == `PM_PAGE_CH1) && (REG_ADDR == `PM_DATA_CMD);
        end
        else
        begin
            sel_page = 1'b0;
            sel_cfg0 = (REG_ADDR == `FUNC_CFG0_ADDR);
            sel_cfg1 = (REG_ADDR == `FUNC_CFG1_ADDR);
            sel_data0 = (REG_ADDR == `DATA0_ADDR);
            sel_data1 = (REG_ADDR == `DATA1_ADDR);
        end
        wr_data_masked = REG_WDATA & DATA_MASK;
        load_evt = pin_fall || SW_LOAD;

        page_next = (REG_WR && sel_page) ? REG_WDATA[7:0] : page_reg;
        wavegen_config_field0_next = (REG_WR && sel_cfg0) ? REG_WDATA : wavegen_config_field0_reg;
        wavegen_config_field1_next = (REG_WR && sel_cfg1) ? REG_WDATA : wavegen_config_field1_reg;
        chan0_output_code_next = (REG_WR && sel_data0) ? wr_data_masked : chan0_output_code_reg;
        chan1_output_code_next = (REG_WR && sel_data1) ? wr_data_masked : chan1_output_code_reg;

        // Immediate update unless the channel waits for a load event
        active0_next = active0_reg;
        if (!wavegen_config_field0_reg[`SYNC_BIT] || load_evt)
            active0_next = chan0_output_code_next[`DATA_MSB:`DATA_LSB];
        active1_next = active1_reg;
        if (!wavegen_config_field1_reg[`SYNC_BIT] || load_evt)
            active1_next = chan1_output_code_next[`DATA_MSB:`DATA_LSB];

        phase0_next = phase_deg(wavegen_config_field0_reg[`PHASE_MSB:`PHASE_LSB]);
        phase1_next = phase_deg(wavegen_config_field1_reg[`PHASE_MSB:`PHASE_LSB]);

        rvalid_next = REG_RD;
        rdata_next = rdata_reg;
        if (REG_RD)
        begin
            if (sel_page)
                rdata_next = {8'h00, page_reg};
            else if (sel_cfg0)
                rdata_next = wavegen_config_field0_reg;
            else if (sel_cfg1)
                rdata_next = wavegen_config_field1_reg;
            else if (sel_data0)
                rdata_next = chan0_output_code_reg;
            else if (sel_data1)
                rdata_next = chan1_output_code_reg;
            else
                rdata_next = 16'h0000;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            page_reg <= `PM_PAGE_RESET;
            wavegen_config_field0_reg <= `CFG_RESET;
            wavegen_config_field1_reg <= `CFG_RESET;
            chan0_output_code_reg <= `DATA_RESET;
            chan1_output_code_reg <= `DATA_RESET;
            active0_reg <= `CODE_RESET;
            active1_reg <= `CODE_RESET;
            phase0_reg <= `PH_DEG_0;
            phase1_reg <= `PH_DEG_0;
            rdata_reg <= 16'h0000;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            page_reg <= page_next;
            wavegen_config_field0_reg <= wavegen_config_field0_next;
            wavegen_config_field1_reg <= wavegen_config_field1_next;
            chan0_output_code_reg <= chan0_output_code_next;
            chan1_output_code_reg <= chan1_output_code_next;
            active0_reg <= active0_next;
            active1_reg <= active1_next;
            phase0_reg <= phase0_next;
            phase1_reg <= phase1_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // ==========
    // Channels; sine shares the triangle sequence, a limitation
    logic [CODE_W-1:0] ch0_code;
    logic [CODE_W-1:0] ch1_code;

    wave_channel #(
        .CODE_W(CODE_W)
    ) u_chan0 (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .tick(tick_reg),
        .cfg(wavegen_config_field0_reg),
        .margin_hi(MARGIN_HIGH0),
        .margin_lo(MARGIN_LOW0),
        .margin_en(MARGIN_EN[0]),
        .margin_high_sel(MARGIN_HIGH_SEL[0]),
        .hold_code(active0_reg),
        .code_out(ch0_code)
    );

    wave_channel #(
        .CODE_W(CODE_W)
    ) u_chan1 (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .tick(tick_reg),
        .cfg(wavegen_config_field1_reg),
        .margin_hi(MARGIN_HIGH1),
        .margin_lo(MARGIN_LOW1),
        .margin_en(MARGIN_EN[1]),
        .margin_high_sel(MARGIN_HIGH_SEL[1]),
        .hold_code(active1_reg),
        .code_out(ch1_code)
    );

    assign OUT_CODE0 = ch0_code;
    assign OUT_CODE1 = ch1_code;
    assign PHASE_DEG0 = phase0_reg;
    assign PHASE_DEG1 = phase1_reg;
    assign REG_RDATA = rdata_reg;
    assign REG_RVALID = rvalid_reg;

endmodule

// [rtl/dac_wave_defines.svh]
`ifndef DAC_WAVE_DEFINES_SVH
`define DAC_WAVE_DEFINES_SVH

// ==========
// Register addresses, direct access
`define FUNC_CFG0_ADDR 8'h18
`define FUNC_CFG1_ADDR 8'h06
`define DATA0_ADDR 8'h1C
`define DATA1_ADDR 8'h19

// ==========
// PMBus command codes and pages
`define PM_PAGE_CMD 8'h00
`define PM_DATA_CMD 8'h21
`define PM_CFG0_CMD 8'hE0
`define PM_CFG1_CMD 8'hD4
`define PM_PAGE_CH0 8'h03
`define PM_PAGE_CH1 8'h00
`define PM_PAGE_COMMON 8'hFF
`define PM_PAGE_RESET 8'hFF

// ==========
// Reset values
`define CFG_RESET 16'h0000
`define DATA_RESET 16'h0000
`define CODE_RESET 12'h000

// ==========
// Field positions
`define SYNC_BIT 14
`define PHASE_MSB 12
`define PHASE_LSB 11
`define WAVE_MSB 10
`define WAVE_LSB 8
`define LOG_BIT 7
`define STEP_MSB 6
`define STEP_LSB 4
`define LRATE_MSB 3
`define LRATE_LSB 0
`define FRATE_MSB 3
`define FRATE_LSB 1
`define DATA_MSB 15
`define DATA_LSB 4

// ==========
// Field encodings
`define WAVE_TRI 3'h0
`define WAVE_SAW 3'h1
`define WAVE_INV 3'h2
`define WAVE_SINE 3'h4
`define WAVE_OFF 3'h7
`define RATE_NOSLEW 4'h0
`define PH_DEG_0 9'h000
`define PH_DEG_120 9'h078
`define PH_DEG_240 9'h0F0
`define PH_DEG_90 9'h05A
`define LOG_SHIFT 5

// ==========
// Time base: one tick every 40 ns
`define CLK_MHZ 250
`define TB_NS 40
`define TB_CYCLES ((`TB_NS * `CLK_MHZ) / 1000)

// Step intervals in ns, converted to time-base ticks
`define IV_TICKS(ns) ((ns) / `TB_NS)
`define IV_4000_NS 4000
`define IV_8000_NS 8000
`define IV_12000_NS 12000
`define IV_18000_NS 18000
`define IV_27040_NS 27040
`define IV_40480_NS 40480
`define IV_60720_NS 60720
`define IV_91120_NS 91120
`define IV_136720_NS 136720
`define IV_239200_NS 239200
`define IV_418640_NS 418640
`define IV_732560_NS 732560
`define IV_1282000_NS 1282000
`define IV_2564000_NS 2564000
`define IV_5127920_NS 5127920

`endif

// [rtl/wave_pkg.sv]
package wave_pkg;
    typedef enum logic [1:0] {ST_HOLD, ST_SLEW, ST_UP, ST_DOWN} chan_state_type;
endpackage

// [rtl/wave_channel.sv]
`timescale 1ns/1ps
`include "dac_wave_defines.svh"

module wave_channel
    import wave_pkg::*;
#(
    parameter int CODE_W = 12,
    parameter int TICK_W = 17
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic [15:0] cfg,
    input wire logic [CODE_W-1:0] margin_hi,
    input wire logic [CODE_W-1:0] margin_lo,
    input wire logic margin_en,
    input wire logic margin_high_sel,
    input wire logic [CODE_W-1:0] hold_code,
    output logic [CODE_W-1:0] code_out
);

    // ==========
    // Table lookups
    function automatic logic [TICK_W-1:0] lin_ticks(input logic [3:0] sel);
        int ns;
        case (sel)
            4'h1: ns = `IV_4000_NS;
            4'h2: ns = `IV_8000_NS;
            4'h3: ns = `IV_12000_NS;
            4'h4: ns = `IV_18000_NS;
            4'h5: ns = `IV_27040_NS;
            4'h6: ns = `IV_40480_NS;
            4'h7: ns = `IV_60720_NS;
            4'h8: ns = `IV_91120_NS;
            4'h9: ns = `IV_136720_NS;
            4'hA: ns = `IV_239200_NS;
            4'hB: ns = `IV_418640_NS;
            4'hC: ns = `IV_732560_NS;
            4'hD: ns = `IV_1282000_NS;
            4'hE: ns = `IV_2564000_NS;
            4'hF: ns = `IV_5127920_NS;
            default: ns = `IV_4000_NS;
        endcase
        lin_ticks = TICK_W'(`IV_TICKS(ns));
    endfunction

    function automatic logic [TICK_W-1:0] log_ticks(input logic [2:0] sel);
        int ns;
        case (sel)
            3'h0: ns = `IV_4000_NS;
            3'h1: ns = `IV_12000_NS;
            3'h2: ns = `IV_27040_NS;
            3'h3: ns = `IV_60720_NS;
            3'h4: ns = `IV_136720_NS;
            3'h5: ns = `IV_418640_NS;
            3'h6: ns = `IV_1282000_NS;
            default: ns = `IV_5127920_NS;
        endcase
        log_ticks = TICK_W'(`IV_TICKS(ns));
    endfunction

    function automatic logic [5:0] lin_step(input logic [2:0] sel);
        case (sel)
            3'h0: lin_step = 6'h01;
            3'h1: lin_step = 6'h02;
            3'h2: lin_step = 6'h03;
            3'h3: lin_step = 6'h04;
            3'h4: lin_step = 6'h06;
            3'h5: lin_step = 6'h08;
            3'h6: lin_step = 6'h10;
            default: lin_step = 6'h20;
        endcase
    endfunction

    // ==========
    // Stepping arithmetic
    chan_state_type state_reg, state_next;
    logic [CODE_W-1:0] code_reg, code_next;
    logic [TICK_W-1:0] cnt_reg, cnt_next;

    logic [2:0] wave;
    logic log_mode;
    logic [CODE_W-1:0] target;
    logic going_up;
    logic [CODE_W-1:0] step;
    logic [CODE_W-1:0] log_inc;
    logic [TICK_W-1:0] interval;
    logic step_evt;
    logic [CODE_W:0] sum_up;
    logic [CODE_W-1:0] up_code;
    logic [CODE_W-1:0] dn_code;
    logic [CODE_W-1:0] slew_up_code;
    logic [CODE_W-1:0] slew_dn_code;

    always_comb
    begin
        wave = cfg[`WAVE_MSB:`WAVE_LSB];
        log_mode = cfg[`LOG_BIT];
        target = margin_high_sel ? margin_hi : margin_lo;
        going_up = (state_reg == ST_DOWN) ? 1'b0 :
                   (state_reg == ST_UP) ? 1'b1 : (target > code_reg);
        log_inc = code_reg >> `LOG_SHIFT;
        if (log_inc == '0)
            log_inc = {{(CODE_W-1){1'b0}}, 1'b1};
        if (log_mode)
            step = log_inc;
        else
            step = {{(CODE_W-6){1'b0}}, lin_step(cfg[`STEP_MSB:`STEP_LSB])};
        if (!log_mode)
            interval = lin_ticks(cfg[`LRATE_MSB:`LRATE_LSB]);
        else if (going_up)
            interval = log_ticks(cfg[`STEP_MSB:`STEP_LSB]);
        else
            interval = log_ticks(cfg[`FRATE_MSB:`FRATE_LSB]);
        step_evt = tick && (cnt_reg >= interval - TICK_W'(1));
        // Clamp against both bounds so a large step never overshoots
        sum_up = {1'b0, code_reg} + {1'b0, step};
        up_code = (sum_up >= {1'b0, margin_hi}) ? margin_hi : sum_up[CODE_W-1:0];
        dn_code = (code_reg <= margin_lo || (code_reg - margin_lo) <= step) ?
                  margin_lo : code_reg - step;
        slew_up_code = (sum_up >= {1'b0, target}) ? target : sum_up[CODE_W-1:0];
        slew_dn_code = (code_reg <= target || (code_reg - target) <= step) ?
                       target : code_reg - step;
    end

    // ==========
    // Sequencing
    always_comb
    begin
        state_next = state_reg;
        code_next = code_reg;
        cnt_next = cnt_reg;
        if (tick)
            cnt_next = step_evt ? '0 : cnt_reg + TICK_W'(1);
        if (wave != `WAVE_OFF)
        begin
            case (state_reg)
                ST_UP:
                begin
                    if (step_evt)
                    begin
                        if (code_reg >= margin_hi)
                        begin
                            if (wave == `WAVE_SAW)
                                code_next = margin_lo;
                            else
                                state_next = ST_DOWN;
                        end
                        else
                            code_next = up_code;
                    end
                end
                ST_DOWN:
                begin
                    if (step_evt)
                    begin
                        if (code_reg <= margin_lo)
                        begin
                            if (wave == `WAVE_INV)
                                code_next = margin_hi;
                            else
                                state_next = ST_UP;
                        end
                        else
                            code_next = dn_code;
                    end
                end
                default:
                begin
                    cnt_next = '0;
                    state_next = (wave == `WAVE_INV) ? ST_DOWN : ST_UP;
                    code_next = (wave == `WAVE_INV) ? margin_hi : margin_lo;
                end
            endcase
        end
        else if (margin_en)
        begin
            state_next = ST_SLEW;
            if (state_reg != ST_SLEW)
                cnt_next = '0;
            if (!log_mode && cfg[`LRATE_MSB:`LRATE_LSB] == `RATE_NOSLEW)
                code_next = target;
            else if (log_mode && going_up && code_reg == '0)
                code_next = {{(CODE_W-1){1'b0}}, 1'b1};
            else if (step_evt && code_reg != target)
                code_next = going_up ? slew_up_code : slew_dn_code;
        end
        else
        begin
            state_next = ST_HOLD;
            code_next = hold_code;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_HOLD;
            code_reg <= `CODE_RESET;
            cnt_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            code_reg <= code_next;
            cnt_reg <= cnt_next;
        end
    end

    assign code_out = code_reg;

endmodule

// [sim/dac_wave_props.sv]
`timescale 1ns/1ps

module dac_wave_props (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic PMBUS_SEL,
    input wire logic [7:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic REG_RVALID,
    input wire logic SW_LOAD,
    input wire logic [11:0] MARGIN_HIGH0,
    input wire logic [11:0] MARGIN_LOW0,
    input wire logic [1:0] MARGIN_EN,
    input wire logic [1:0] MARGIN_HIGH_SEL,
    input wire logic [11:0] OUT_CODE0,
    input wire logic [8:0] PHASE_DEG0
);
    // ==========================================
    // Shadow of channel 0 config and data, direct writes only
    logic [15:0] cfg_reg;
    logic [15:0] cfg_next;
    logic [11:0] dat_reg;
    logic [11:0] dat_next;
    wire logic wc = REG_WR && !PMBUS_SEL && REG_ADDR == 8'h18;
    wire logic wd = REG_WR && !PMBUS_SEL && REG_ADDR == 8'h1C;
    wire logic wo = cfg_reg[10:8] == 3'h7;
    wire logic quiet = wo && !MARGIN_EN[0];
    wire logic lin0 = !cfg_reg[7] && cfg_reg[3:0] == 4'h0;

    always_comb
    begin
        cfg_next = wc ? REG_WDATA : cfg_reg;
        dat_next = wd ? REG_WDATA[15:4] : dat_reg;
    end

    always_ff @(posedge SYS_CLK)
    begin
        cfg_reg <= RST_N ? cfg_next : 16'h0000;
        dat_reg <= RST_N ? dat_next : 12'h000;
    end

    function automatic logic [8:0] deg(input logic [1:0] s);
        return s == 2'h0 ? 9'h000 : s == 2'h1 ? 9'h078 : s == 2'h2 ? 9'h0F0 : 9'h05A;
    endfunction

    // ==========================================
    // Properties
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);

    sequence s_to_high;
        (wo && lin0 && MARGIN_EN[0] && MARGIN_HIGH_SEL[0]) [*2];
    endsequence
    sequence s_wave_run;
        (!wo) [*4];
    endsequence

    property p_rd_ans;
        REG_RD |=> REG_RVALID;
    endproperty
    property p_rv_cause;
        REG_RVALID |-> $past(REG_RD);
    endproperty
    property p_reset;
        $rose(RST_N) |-> OUT_CODE0 == 12'h000 && !REG_RVALID;
    endproperty
    property p_phase;
        wc |-> ##2 PHASE_DEG0 == deg($past(REG_WDATA[12:11], 2));
    endproperty
    property p_now;
        wd && !cfg_reg[14] && quiet |-> ##2 OUT_CODE0 == $past(REG_WDATA[15:4], 2);
    endproperty
    property p_hold;
        wd && cfg_reg[14] && quiet |-> ##1 $stable(OUT_CODE0) [*3];
    endproperty
    property p_load;
        SW_LOAD && !REG_WR && cfg_reg[14] && quiet |-> ##2 OUT_CODE0 == dat_reg;
    endproperty
    property p_jump;
        s_to_high |=> OUT_CODE0 == MARGIN_HIGH0;
    endproperty
    property p_clamp;
        s_wave_run |-> OUT_CODE0 >= MARGIN_LOW0 && OUT_CODE0 <= MARGIN_HIGH0;
    endproperty

    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    a_rv_cause: assert property (p_rv_cause) else $error("stray read valid");
    a_reset: assert property (p_reset) else $error("output not zero after reset");
    a_phase: assert property (p_phase) else $error("phase decode wrong");
    a_now: assert property (p_now) else $error("immediate update wrong");
    a_hold: assert property (p_hold) else $error("deferred update leaked");
    a_load: assert property (p_load) else $error("load trigger missed");
    a_jump: assert property (p_jump) else $error("no-slew jump wrong");
    a_clamp: assert property (p_clamp) else $error("code outside margins");
endmodule

bind dac_wave_top dac_wave_props props_u (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .PMBUS_SEL(PMBUS_SEL), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RVALID(REG_RVALID), .SW_LOAD(SW_LOAD),
    .MARGIN_HIGH0(MARGIN_HIGH0), .MARGIN_LOW0(MARGIN_LOW0), .MARGIN_EN(MARGIN_EN),
    .MARGIN_HIGH_SEL(MARGIN_HIGH_SEL), .OUT_CODE0(OUT_CODE0), .PHASE_DEG0(PHASE_DEG0));

// [sim/host_model.sv]
`timescale 1ns/1ps

module host_model (
    input wire logic clk,
    input wire logic [15:0] rdata,
    input wire logic rvalid,
    output logic pm_sel,
    output logic [7:0] addr,
    output logic [15:0] wdata,
    output logic wr,
    output logic rd
);
    initial {pm_sel, addr, wdata, wr, rd} = 27'h0;

    // Released lines show inverted values so stale data cannot pass
    task automatic put(input logic s, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        pm_sel <= s;
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask

    task automatic get(input logic s, input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        pm_sel <= s;
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        @(posedge clk);
        d = rvalid ? rdata : 16'hXXXX;
    endtask
endmodule

// [sim/dac_wave_top_tb.sv]
`timescale 1ns/1ps

module dac_wave_top_tb;
    localparam logic [8:0] PH [4] = '{9'h000, 9'h078, 9'h0F0, 9'h05A};
    localparam logic [11:0] STEP [8] = '{12'h001, 12'h002, 12'h003, 12'h004,
        12'h006, 12'h008, 12'h010, 12'h020};
    localparam logic [2:0] WV [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
    logic SYS_CLK = 1'b0;
    logic RST_N = 1'b0;
    logic load_n = 1'b1;
    logic sw_load = 1'b0;
    logic [1:0] m_en = 2'h0;
    logic [1:0] m_sel = 2'h0;
    logic [11:0] mh0 = 12'h0F0, ml0 = 12'h010, mh1 = 12'h3FF, ml1 = 12'h000;
    logic pm_sel, wr, rd, rvalid;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, v;
    logic [11:0] out0, out1, prev;
    logic [8:0] ph0;
    int err_count = 0;
    int n_checks = 0;
    int n;

    initial forever #2 SYS_CLK = ~SYS_CLK;

    host_model host_u (.clk(SYS_CLK), .rdata(rdata), .rvalid(rvalid), .pm_sel(pm_sel),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

    dac_wave_top #(.RES_BITS(12), .TICK_CYCLES(1)) dut_u (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
        .PMBUS_SEL(pm_sel), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
        .REG_RDATA(rdata), .REG_RVALID(rvalid), .LOAD_OUTPUT_TRIGGER_N(load_n),
        .SW_LOAD(sw_load), .MARGIN_HIGH0(mh0), .MARGIN_LOW0(ml0),
        .MARGIN_HIGH1(mh1), .MARGIN_LOW1(ml1), .MARGIN_EN(m_en),
        .MARGIN_HIGH_SEL(m_sel), .OUT_CODE0(out0), .OUT_CODE1(out1), .PHASE_DEG0(ph0),
        .PHASE_DEG1());

    // ==========================================
    // Compare and access tasks
    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t reg %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_code(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t code %h exp %h", $time, got, exp);
        end
    endtask

    task automatic rdc(input logic s, input logic [7:0] a, input logic [15:0] e);
        host_u.get(s, a, v);
        chk_reg(v, e);
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge SYS_CLK);
    endtask

    task automatic wchg(input logic ch);
        prev = ch ? out1 : out0;
        n = 0;
        while ((ch ? out1 : out0) === prev && n < 400)
        begin
            @(posedge SYS_CLK);
            n++;
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        #120000;
        err_count++;
        close_out();
    end

    // ==========================================
    // Tests
    initial
    begin
        cyc(10);
        RST_N <= 1'b1;
        rdc(0, 8'h1C, 16'h0000);
        rdc(0, 8'h19, 16'h0000);
        rdc(0, 8'h30, 16'h0000);
        rdc(1, 8'h00, 16'h00FF);
        host_u.put(0, 8'h18, 16'h0700);
        host_u.put(0, 8'h06, 16'h0700);
        host_u.put(0, 8'h1C, 16'hABCD);
        cyc(4);
        chk_code(out0, 12'hABC);
        rdc(0, 8'h1C, 16'hABC0);
        host_u.put(1, 8'h00, 16'h0000);
        host_u.put(1, 8'h21, 16'h5A5F);
        cyc(4);
        chk_code(out1, 12'h5A5);
        rdc(0, 8'h19, 16'h5A50);
        host_u.put(1, 8'h00, 16'h0003);
        rdc(1, 8'h21, 16'hABC0);
        $display("test data done");
        for (int i = 0; i < 4; i++)
        begin
            host_u.put(0, 8'h18, {3'h0, 2'(i), 11'h700});
            cyc(4);
            chk_code({3'h0, ph0}, {3'h0, PH[i]});
        end
        host_u.put(0, 8'h18, 16'h4700);
        host_u.put(0, 8'h1C, 16'h1230);
        cyc(6);
        chk_code(out0, 12'hABC);
        sw_load <= 1'b1;
        cyc(1);
        sw_load <= 1'b0;
        cyc(4);
        chk_code(out0, 12'h123);
        host_u.put(0, 8'h1C, 16'h4560);
        load_n <= 1'b0;
        cyc(12);
        load_n <= 1'b1;
        chk_code(out0, 12'h456);
        $display("test load done");
        host_u.put(0, 8'h18, 16'h0700);
        m_en <= 2'h1;
        m_sel <= 2'h1;
        cyc(4);
        chk_code(out0, 12'h0F0);
        for (int k = 0; k < 8; k++)
        begin
            m_sel <= 2'h0;
            host_u.put(0, 8'h18, 16'h0700);
            cyc(4);
            chk_code(out0, 12'h010);
            host_u.put(0, 8'h18, {9'h00E, 3'(k), 4'h1});
            m_sel <= 2'h1;
            wchg(1'b0);
            chk_code(out0, 12'h010 + STEP[k]);
            wchg(1'b0);
            chk_code(12'(n), 12'h064);
        end
        $display("test slew done");
        m_en <= 2'h0;
        host_u.put(0, 8'h19, 16'h0000);
        host_u.put(0, 8'h06, 16'h0780);
        cyc(4);
        m_en <= 2'h2;
        m_sel <= 2'h2;
        for (int i = 0; i < 70; i++)
        begin
            wchg(1'b1);
            chk_code(out1, prev + ((prev >> 5) > 0 ? prev >> 5 : 12'h001));
        end
        m_sel <= 2'h0;
        for (int i = 0; i < 4; i++)
        begin
            wchg(1'b1);
            chk_code(out1, prev - ((prev >> 5) > 0 ? prev >> 5 : 12'h001));
        end
        $display("test log done");
        m_en <= 2'h0;
        for (int i = 0; i < 4; i++)
        begin
            host_u.put(0, 8'h18, 16'h0700);
            host_u.put(0, 8'h18, {5'h0, WV[i], 8'h71});
            cyc(4);
            chk_code(out0, WV[i] == 3'h2 ? 12'h0F0 : 12'h010);
            wchg(1'b0);
            chk_code(out0, WV[i] == 3'h2 ? 12'h0D0 : 12'h030);
        end
        $display("test wave done");
        close_out();
    end
endmodule
